// ---- core/dipc_chain_if.sv ----
`default_nettype none
`include "dipc_map.svh"
interface dipc_chain_if;
    logic hold_req_n;
    logic hold_ack;
    logic [`DIPC_VI_LINES-1:0] vi_n_dev;
    logic [`DIPC_VI_LINES-1:0] vi_n_ext;
    modport device (
        input hold_req_n,
        output hold_ack,
        output vi_n_dev,
        input vi_n_ext
    );
    modport other (
        output hold_req_n,
        input hold_ack,
        input vi_n_dev,
        output vi_n_ext
    );
endinterface
`default_nettype wire

// ---- core/dipc_device.sv ----
`default_nettype none
`include "dipc_map.svh"
module dipc_device (
    input wire logic core_clk, // system clock
    input wire logic rst, // async reset, active high
    dipc_chain_if.device chain, // bus side chain lines
    input wire logic xfer_req, // on-board controller wants bus
    input wire logic xfer_done, // on-board controller releases bus
    input wire logic [`DIPC_VI_LINES-1:0] irq_pend, // per-board pending interrupt
    input wire logic processor_bus_ack_n, // processor acknowledge
    output logic bus_request_n, // request to processor
    output logic xfer_owns, // on-board controller owns bus
    output logic [`DIPC_VI_LINES-1:0] irq_enable // board may interrupt
);
    import dipc_pkg::*;

    dipc_state_t state_q;
    dipc_state_t state_d;
    logic grant_chain_in_n;
    logic grant_chain_out_n;
    logic down_req_q;
    logic onboard_wants;
    logic bus_request_d;
    logic keep_grant;
    logic pass_grant;
    logic owns_d;
    logic hold_ack_q;
    logic vi_line0_q;
    logic [`DIPC_VI_LINES-1:0] chain_lines;
    logic [`DIPC_VI_LINES-1:0] en_q;

    // the processor's acknowledge is our grant input, so we rank first
    assign grant_chain_in_n = processor_bus_ack_n;

    // the downstream grant goes out on the hold-acknowledge line
    assign grant_chain_out_n = ~hold_ack_q;
    assign chain.hold_ack = ~grant_chain_out_n;

    // only the top line is ours; each lower board drives its own line
    assign chain.vi_n_dev = {{(`DIPC_VI_LINES-1){`DIPC_RELEASED}}, vi_line0_q};

    // a line is low when either end blocks the boards below it
    assign chain_lines = chain.vi_n_dev & chain.vi_n_ext;

    // on-board side wants the bus while requesting, waiting or owning
    always_comb begin
        onboard_wants = (state_q != DIPC_IDLE) || (xfer_req && !hold_ack_q);
    end

    // hold-request from the bus reaches the processor request as well
    always_comb begin
        bus_request_d = !(onboard_wants || !chain.hold_req_n);
    end

    // a granted downstream owner keeps the bus until it lets go
    always_comb begin
        keep_grant = down_req_q && !grant_chain_in_n;
    end

    // both asking before the ack: the on-board side wins
    always_comb begin
        pass_grant = !grant_chain_in_n && down_req_q && !onboard_wants;
    end

    always_comb begin
        owns_d = 1'b0;
        if (state_q == DIPC_WAIT && !grant_chain_in_n) begin
            owns_d = 1'b1;
        end else if (state_q == DIPC_OWN && !xfer_done) begin
            owns_d = 1'b1;
        end
    end

    // on-board controller: request, wait for grant, own until done
    always_comb begin
        state_d = state_q;
        case (state_q)
            DIPC_IDLE: begin
                // a downstream owner is never pre-empted
                if (xfer_req && !hold_ack_q) begin
                    state_d = DIPC_WAIT;
                end
            end
            DIPC_WAIT: begin
                if (!grant_chain_in_n) begin
                    state_d = DIPC_OWN;
                end
            end
            DIPC_OWN: begin
                if (xfer_done) begin
                    state_d = DIPC_IDLE;
                end
            end
            default: begin
                state_d = DIPC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= DIPC_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // registered so a glitch on the bus line cannot reach the grant
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            down_req_q <= 1'b0;
        end else begin
            down_req_q <= ~chain.hold_req_n;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_request_n <= `DIPC_RELEASED;
        end else begin
            bus_request_n <= bus_request_d;
        end
    end

    // grant passes down only when not wanted here; held once given
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hold_ack_q <= 1'b0;
        end else if (hold_ack_q) begin
            hold_ack_q <= keep_grant;
        end else begin
            hold_ack_q <= pass_grant;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            xfer_owns <= 1'b0;
        end else begin
            xfer_owns <= owns_d;
        end
    end

    // interrupt chain: board k enabled unless a higher board drives its line
    genvar k;
    generate
        for (k = 0; k < `DIPC_VI_LINES; k++) begin : g_vi
            if (k == 0) begin : g_top
                // nobody ranks above the top board
                always_ff @(posedge core_clk or posedge rst) begin
                    if (rst) begin
                        en_q[k] <= 1'b0;
                    end else begin
                        en_q[k] <= 1'b1;
                    end
                end
            end else begin : g_lower
                always_ff @(posedge core_clk or posedge rst) begin
                    if (rst) begin
                        en_q[k] <= 1'b0;
                    end else begin
                        en_q[k] <= &chain_lines[k-1:0];
                    end
                end
            end
        end
    endgenerate

    // our line blocks every other board while we have one pending
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            vi_line0_q <= `DIPC_RELEASED;
        end else begin
            vi_line0_q <= ~(irq_pend[0] & en_q[0]);
        end
    end

    // only bit 0 of irq_pend belongs here; the rest show the chain state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_enable <= '0;
        end else begin
            irq_enable <= en_q;
        end
    end

endmodule
`default_nettype wire

// ---- core/dipc_map.svh ----
`ifndef DIPC_MAP_SVH
`define DIPC_MAP_SVH
// number of interrupt chain lines on the bus (one for the on-board end plus one per extra board)
`define DIPC_VI_LINES 8
`define DIPC_EXTRA_BOARDS 7
// reset value of active-low lines: released
`define DIPC_RELEASED 1'b1
`endif

// ---- core/dipc_other.sv ----
`default_nettype none
`include "dipc_map.svh"
module dipc_other (
    input wire logic core_clk, // system clock
    input wire logic rst, // async reset, active high
    dipc_chain_if.other chain, // bus side chain lines
    input wire logic dma_req, // downstream controller group wants bus
    input wire logic [`DIPC_VI_LINES-1:0] irq_pend, // per-board pending interrupt
    output logic dma_granted // group owns bus
);
    import dipc_pkg::*;
    logic req_n_q;
    logic [`DIPC_VI_LINES-1:0] vi_q;

    assign chain.hold_req_n = req_n_q;
    assign chain.vi_n_ext = vi_q;

    // acts as one controller: low request until done
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            req_n_q <= `DIPC_RELEASED;
            dma_granted <= 1'b0;
        end else begin
            req_n_q <= ~dma_req;
            dma_granted <= dma_req && chain.hold_ack;
        end
    end

    // board k drives line k while pending, gated by higher lines
    genvar k;
    generate
        for (k = 0; k < `DIPC_VI_LINES; k++) begin : g_vi
            if (k == 0) begin : g_top
                // the top line belongs to the on-board end
                always_ff @(posedge core_clk or posedge rst) begin
                    if (rst) begin
                        vi_q[k] <= `DIPC_RELEASED;
                    end else begin
                        vi_q[k] <= `DIPC_RELEASED;
                    end
                end
            end else begin : g_lower
                always_ff @(posedge core_clk or posedge rst) begin
                    if (rst) begin
                        vi_q[k] <= `DIPC_RELEASED;
                    end else begin
                        vi_q[k] <= ~(irq_pend[k]
                            & (&(chain.vi_n_dev[k-1:0] & chain.vi_n_ext[k-1:0])));
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ---- core/dipc_pkg.sv ----
`default_nettype none
package dipc_pkg;
    typedef enum logic [2:0] {
        DIPC_IDLE = 3'b001,
        DIPC_WAIT = 3'b010,
        DIPC_OWN = 3'b100
    } dipc_state_t;
endpackage
`default_nettype wire

// ---- verification/dipc_chain_sva.sv ----
`default_nettype none
`include "dipc_map.svh"
module dipc_chain_sva (
    input wire logic core_clk, // clock
    input wire logic rst, // async reset
    input wire logic hold_req_n, // downstream request
    input wire logic hold_ack, // downstream grant
    input wire logic [`DIPC_VI_LINES-1:0] vi_n_dev, // device chain lines
    input wire logic [`DIPC_VI_LINES-1:0] vi_n_ext // external chain lines
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // four cycles covers the registered request plus the grant flop
    sequence s_idle; hold_req_n [*4]; endsequence
    property p_idle; s_idle |-> !hold_ack; endproperty
    a_idle: assert property (p_idle) else $error("grant while idle");
    property p_rise; $rose(hold_ack) |-> $past(!hold_req_n); endproperty
    a_rise: assert property (p_rise) else $error("grant without request");
    property p_hold; hold_ack && !hold_req_n |=> hold_ack; endproperty
    a_hold: assert property (p_hold) else $error("owner pre-empted");
    property p_drop; $rose(hold_req_n) |-> ##[1:3] !hold_ack; endproperty
    a_drop: assert property (p_drop) else $error("grant kept");
    property p_lat; $fell(hold_req_n) && !hold_ack |=> !hold_ack; endproperty
    a_lat: assert property (p_lat) else $error("grant too early");
    property p_reset; $fell(rst) |-> !hold_ack && (&vi_n_dev) && (&vi_n_ext); endproperty
    a_reset: assert property (p_reset) else $error("bad reset value");
    property p_vi_top; &vi_n_dev[`DIPC_VI_LINES-1:1]; endproperty
    a_vi_top: assert property (p_vi_top) else $error("device drives board line");
    property p_ext0; vi_n_ext[0]; endproperty
    a_ext0: assert property (p_ext0) else $error("board drives top line");
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
`default_nettype none
`include "dipc_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 0, rst = 1, xfer_req = 0, xfer_done = 0, dma_req = 0, proc_ack_n = 1;
    logic [`DIPC_VI_LINES-1:0] irq_dev = 8'h00, irq_ext = 8'h00, irq_enable;
    logic bus_request_n, xfer_owns, dma_granted;
    int miscompares = 0, checks_done = 0, n;
    dipc_chain_if chain ();
    dipc_device i_dipc_device (.core_clk(core_clk), .rst(rst), .chain(chain),
        .xfer_req(xfer_req), .xfer_done(xfer_done), .irq_pend(irq_dev),
        .processor_bus_ack_n(proc_ack_n), .bus_request_n(bus_request_n),
        .xfer_owns(xfer_owns), .irq_enable(irq_enable));
    dipc_other i_dipc_other (.core_clk(core_clk), .rst(rst), .chain(chain),
        .dma_req(dma_req), .irq_pend(irq_ext), .dma_granted(dma_granted));
    dipc_chain_sva i_dipc_chain_sva (.core_clk(core_clk), .rst(rst),
        .hold_req_n(chain.hold_req_n), .hold_ack(chain.hold_ack),
        .vi_n_dev(chain.vi_n_dev), .vi_n_ext(chain.vi_n_ext));
    // processor: both requests share one wired-low line, ack one cycle later
    always @(posedge core_clk) proc_ack_n <= #1 bus_request_n & chain.hold_req_n;
    initial forever #2.5 core_clk = ~core_clk;
    task automatic step(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    task automatic check(input logic seen, input logic exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %b want %b", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_reset;
        check(bus_request_n, 1'b1);
        check(xfer_owns, 1'b0);
        check(dma_granted, 1'b0);
        check(chain.hold_ack, 1'b0);
        $display("reset test done");
    endtask
    task automatic t_simul;
        xfer_req = 1;
        dma_req = 1;
        for (n = 0; n < 20 && xfer_owns !== 1'b1; n++) step(1);
        check(xfer_owns, 1'b1);
        check(bus_request_n, 1'b0);
        step(5);
        check(dma_granted, 1'b0);
        check(chain.hold_ack, 1'b0);
        xfer_done = 1;
        xfer_req = 0;
        step(1);
        xfer_done = 0;
        for (n = 0; n < 20 && dma_granted !== 1'b1; n++) step(1);
        check(dma_granted, 1'b1);
        check(chain.hold_ack, 1'b1);
        $display("simultaneous test done");
    endtask
    task automatic t_no_preempt;
        xfer_req = 1;
        step(8);
        check(xfer_owns, 1'b0);
        check(dma_granted, 1'b1);
        dma_req = 0;
        for (n = 0; n < 20 && xfer_owns !== 1'b1; n++) step(1);
        check(xfer_owns, 1'b1);
        xfer_done = 1;
        xfer_req = 0;
        step(1);
        xfer_done = 0;
        step(4);
        check(bus_request_n, 1'b1);
        $display("pre-empt test done");
    endtask
    task automatic t_irq;
        irq_ext = 8'h04;
        step(3);
        check(|irq_enable[`DIPC_VI_LINES-1:3], 1'b0);
        check(chain.vi_n_ext[2], 1'b0);
        irq_ext = 8'h00;
        irq_dev = 8'h01;
        step(3);
        check(chain.vi_n_dev[0], 1'b0);
        check(irq_enable[1], 1'b0);
        irq_dev = 8'h00;
        step(3);
        check(irq_enable[`DIPC_VI_LINES-1], 1'b1);
        $display("interrupt chain test done");
    endtask
    initial begin
        step(20);
        rst = 0;
        step(1);
        t_reset();
        t_simul();
        t_no_preempt();
        t_irq();
        report_and_stop();
    end
    // the tests need well under a thousand cycles
    initial begin
        #20000;
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
